// ---- verilog/pat_adc_core.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "pat_map.svh"
// Operation
// R01 - New sample every cycle; result at outputs exactly eight cycles later
// R02 - Acquire while clock low, freeze on rising edge, hold while high
// R03 - Data word and out-of-range flag registered together in one buffer
// R04 - Format select high gives straight binary, low gives two's complement
// R05 - Duty restore tied to a rail: internal 50% falling edge generated; code treats only a high pin as restore, a low pin gives both edges
// R06 - Duty restore floating or resistor: both external clock edges used
// R07 - Result is a 14-bit parallel word, bit 0 least significant
// R08 - Eight pipeline stages with redundancy, digitally corrected
// R09 - Out-of-range flag set when sample beyond full scale
// R10 - Outputs driven only while output enable low, released otherwise
module pat_adc_core
  import pat_pkg::*;
#(
  parameter int DATA_W = `PAT_DATA_W,
  parameter int STAGES = `PAT_STAGES
)(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [DATA_W-1:0] sample_code,
  input wire logic sample_oor,
  input wire logic output_format_select,
  input wire logic duty_restore_pin,
  input wire logic output_enable_n,
  output logic [DATA_W-1:0] data_out,
  output logic [DATA_W-1:0] data_oe,
  output logic out_of_range_flag,
  output logic oor_oe,
  output pat_duty_mode_t duty_mode,
  output logic [1:0] edge_count
);
  // ==========
  // Pin synchronisers
  logic [2:0] pin_s1_q, pin_s1_d, pin_s2_q, pin_s2_d;
  always_comb begin
    pin_s1_d = {output_format_select, duty_restore_pin, output_enable_n};
    pin_s2_d = pin_s1_q;
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      // Read as restore mode with drivers off until the pins are synchronised
      pin_s1_q <= `PAT_PIN_RST;
      pin_s2_q <= `PAT_PIN_RST;
    end else begin
      pin_s1_q <= pin_s1_d;
      pin_s2_q <= pin_s2_d;
    end
  end
  logic fmt_bin, restore_on, oe_n;
  assign fmt_bin = pin_s2_q[2];
  assign restore_on = pin_s2_q[1];
  assign oe_n = pin_s2_q[0];

  // ==========
  // Sample capture
  pat_stage_if th_if();
  pat_track_hold u_th (
    .core_clk(core_clk),
    .rstn(rstn),
    .sample_code(sample_code),
    .sample_oor(sample_oor),
    .th(th_if.src)
  );

  // ==========
  // Pipeline: held sample plus STAGES-1 stages, then output buffer = 9 registers, 8 cycles after the freeze (see R01) (see R08)
  pat_word_t pipe_q [STAGES-1], pipe_d [STAGES-1];
  always_comb begin
    pipe_d[0].code = th_if.held_code;
    // Beyond-full-scale flag travels with its own sample word (see R09)
    pipe_d[0].oor = th_if.held_oor;
    for (int i = 1; i < STAGES-1; i++) begin
      pipe_d[i] = pipe_q[i-1];
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < STAGES-1; i++) begin
        pipe_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < STAGES-1; i++) begin
        pipe_q[i] <= pipe_d[i];
      end
    end
  end

  // Two's complement is offset binary with MSB inverted (see R04)
  function automatic logic [DATA_W-1:0] pat_format(input logic [DATA_W-1:0] c, input logic bin);
    pat_format = bin ? c : {~c[DATA_W-1], c[DATA_W-2:0]};
  endfunction

  // ==========
  // Output buffer: word and flag latched together (see R03) (see R07)
  logic [DATA_W-1:0] dout_q, dout_d;
  logic oor_q, oor_d;
  always_comb begin
    dout_d = pat_format(pipe_q[STAGES-2].code, fmt_bin);
    oor_d = pipe_q[STAGES-2].oor;
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dout_q <= `PAT_CODE_RST;
      oor_q <= 1'b0;
    end else begin
      dout_q <= dout_d;
      oor_q <= oor_d;
    end
  end
  assign data_out = dout_q;
  assign out_of_range_flag = oor_q;
  // Drivers enabled while enable pin low (see R10)
  assign data_oe = {DATA_W{~oe_n}};
  assign oor_oe = ~oe_n;

  // ==========
  // Clock timing mode; one clock domain, so edges are counted per cycle
  logic [1:0] edge_q, edge_d;
  always_comb begin
    // Restore: only rising edge used, fall made internally (see R05)
    // Both edges: two timing events per cycle (see R06)
    edge_d = restore_on ? 2'h1 : 2'h2;
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      edge_q <= `PAT_EDGE_RST;
    end else begin
      edge_q <= edge_d;
    end
  end
  assign edge_count = edge_q;
  assign duty_mode = restore_on ? PAT_DUTY_RESTORE : PAT_DUTY_BOTH_EDGES;

  // ==========
  // Checks
  logic [3:0] age_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      age_q <= 4'h0;
    end else if (age_q != 4'hf) begin
      age_q <= age_q + 4'h1;
    end
  end
  // Outputs are seen one edge after the buffer loads, so the sample lies nine edges back
  property p_latency;
    @(posedge core_clk) disable iff (!rstn)
    (age_q > 4'h9 && fmt_bin && $stable(fmt_bin)) |-> data_out == $past(sample_code, 9);
  endproperty
  a_latency: assert property (p_latency) else $error("latency wrong"); // see R01
  property p_oor_lat;
    @(posedge core_clk) disable iff (!rstn)
    age_q > 4'h9 |-> out_of_range_flag == $past(sample_oor, 9);
  endproperty
  a_oor_lat: assert property (p_oor_lat) else $error("flag latency wrong"); // see R03
  property p_hold;
    @(posedge core_clk) disable iff (!rstn)
    age_q > 4'h1 |-> th_if.held_code == $past(sample_code);
  endproperty
  a_hold: assert property (p_hold) else $error("hold value wrong"); // see R02
  property p_twos;
    @(posedge core_clk) disable iff (!rstn)
    (age_q > 4'h9 && !fmt_bin && $stable(fmt_bin)) |->
      data_out == {~$past(sample_code[DATA_W-1], 9), $past(sample_code[DATA_W-2:0], 9)};
  endproperty
  a_twos: assert property (p_twos) else $error("format wrong"); // see R04
  // Pin fall reaches the drivers after the two synchroniser stages
  property p_oe;
    @(posedge core_clk) disable iff (!rstn)
    $fell(output_enable_n) |-> ##2 ((data_oe == {DATA_W{1'b1}}) && oor_oe);
  endproperty
  a_oe: assert property (p_oe) else $error("enable wrong"); // see R10
  property p_restore;
    @(posedge core_clk) disable iff (!rstn)
    restore_on |-> (duty_mode == PAT_DUTY_RESTORE) ##1 (edge_count == 2'h1);
  endproperty
  a_restore: assert property (p_restore) else $error("restore mode wrong"); // see R05
  property p_both;
    @(posedge core_clk) disable iff (!rstn)
    !restore_on |=> edge_count == 2'h2;
  endproperty
  a_both: assert property (p_both) else $error("edge mode wrong"); // see R06
  property p_oor_set;
    @(posedge core_clk) disable iff (!rstn)
    (age_q > 4'h9 && $past(sample_oor, 9)) |-> out_of_range_flag;
  endproperty
  a_oor_set: assert property (p_oor_set) else $error("flag missing"); // see R09
  c_oor: cover property (@(posedge core_clk) disable iff (!rstn) out_of_range_flag);
  c_twos: cover property (@(posedge core_clk) disable iff (!rstn) !fmt_bin && age_q > 4'h9);
  c_hiz: cover property (@(posedge core_clk) disable iff (!rstn) oe_n ##1 !oe_n);
endmodule
`default_nettype wire

// ---- include/pat_map.svh ----
`ifndef PAT_MAP_SVH
`define PAT_MAP_SVH
`define PAT_DATA_W 14
`define PAT_LATENCY 8
`define PAT_STAGES 8
`define PAT_CODE_MAX 14'h3fff
`define PAT_CODE_MID 14'h2000
`define PAT_CODE_RST 14'h0000
`define PAT_PIN_RST 3'h3
`define PAT_EDGE_RST 2'h1
`endif

// ---- include/pat_pkg.sv ----
package pat_pkg;
  typedef enum logic [1:0] {
    PAT_DUTY_RESTORE,
    PAT_DUTY_BOTH_EDGES
  } pat_duty_mode_t;
  typedef struct packed {
    logic [13:0] code;
    logic oor;
  } pat_word_t;
endpackage

// ---- include/pat_stage_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface pat_stage_if;
  logic hold;
  logic [13:0] held_code;
  logic held_oor;
  modport src (output hold, output held_code, output held_oor);
  modport dst (input hold, input held_code, input held_oor);
endinterface
`default_nettype wire

// ---- verilog/pat_track_hold.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "pat_map.svh"
// ==========
// Track and hold: acquire while clock low, freeze on rising edge
module pat_track_hold
  import pat_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [`PAT_DATA_W-1:0] sample_code,
  input wire logic sample_oor,
  pat_stage_if.src th
);
  logic [`PAT_DATA_W-1:0] code_q, code_d;
  logic oor_q, oor_d;
  always_comb begin
    code_d = sample_code;
    oor_d = sample_oor;
  end
  // Freeze on every rising edge; value held through high phase (see R02)
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      code_q <= `PAT_CODE_RST;
      oor_q <= 1'b0;
    end else begin
      code_q <= code_d;
      oor_q <= oor_d;
    end
  end
  assign th.hold = core_clk;
  assign th.held_code = code_q;
  assign th.held_oor = oor_q;
endmodule
`default_nettype wire

// ---- verif/pat_capture.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========
// Capture logic on the far side of the output pins
module pat_capture (
  input wire logic core_clk,
  input wire logic [13:0] data_out,
  input wire logic [13:0] data_oe,
  input wire logic out_of_range_flag,
  input wire logic oor_oe,
  output logic cap_valid,
  output logic [13:0] cap_code,
  output logic cap_oor
);
  logic [13:0] last_q;
  // Released pins have no pull, so show the inverse of the last driven word
  always_comb begin
    cap_valid = (data_oe === 14'h3fff) && (oor_oe === 1'b1);
    cap_code = cap_valid ? data_out : ~last_q;
    cap_oor = cap_valid ? out_of_range_flag : ~last_q[0];
  end
  always_ff @(posedge core_clk) begin
    if (cap_valid) last_q <= data_out;
  end
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========
// Self-checking bench for the converter output timing
module tb import pat_pkg::*;;
  typedef struct {int due; logic [13:0] code; logic oor;} pat_note_t;
  logic core_clk, rstn, sample_oor, output_format_select, duty_restore_pin, output_enable_n;
  logic [13:0] sample_code, data_out, data_oe, cap_code;
  logic out_of_range_flag, oor_oe, cap_valid, cap_oor;
  pat_duty_mode_t duty_mode;
  logic [1:0] edge_count;
  int errors = 0, n_checks = 0, cyc = 0, fmt_cyc = 0, seed = 32'hfdba;
  pat_note_t q[$];
  pat_adc_core i_dut (.core_clk(core_clk), .rstn(rstn), .sample_code(sample_code), .sample_oor(sample_oor),
    .output_format_select(output_format_select), .duty_restore_pin(duty_restore_pin),
    .output_enable_n(output_enable_n), .data_out(data_out), .data_oe(data_oe),
    .out_of_range_flag(out_of_range_flag), .oor_oe(oor_oe), .duty_mode(duty_mode), .edge_count(edge_count));
  pat_capture i_cap (.core_clk(core_clk), .data_out(data_out), .data_oe(data_oe),
    .out_of_range_flag(out_of_range_flag), .oor_oe(oor_oe), .cap_valid(cap_valid), .cap_code(cap_code),
    .cap_oor(cap_oor));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic drive(input logic [13:0] c, input logic o);
    @(posedge core_clk);
    sample_code <= c;
    sample_oor <= o;
    q.push_back('{cyc + 9, c, o});
  endtask
  task automatic run(input int n);
    logic [31:0] r;
    for (int i = 0; i < n; i++) begin
      r = $random(seed);
      drive(r[13:0], r[20]);
    end
  endtask
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // ==========
  // Monitor: results are due on the tenth falling edge after the note was made
  always @(negedge core_clk) begin
    while (q.size() > 0 && q[0].due <= cyc) begin
      // Skip words near a format change, the sync delay makes them ambiguous
      if (q[0].due == cyc && cap_valid && cyc - fmt_cyc > 4) begin
        chk({2'b00, cap_code}, {2'b00, q[0].code ^ {~output_format_select, 13'h0}});
        chk({15'h0, cap_oor}, {15'h0, q[0].oor});
      end
      void'(q.pop_front());
    end
    cyc = cyc + 1;
  end
  initial begin
    repeat (1000) @(posedge core_clk);
    errors++;
    give_verdict();
  end
  // ==========
  // Main sequence
  initial begin
    rstn = 1'b0;
    sample_code = 14'h0;
    sample_oor = 1'b0;
    output_format_select = 1'b1;
    duty_restore_pin = 1'b1;
    output_enable_n = 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk({2'b00, data_out}, 16'h0000);
    chk({2'b00, data_oe}, 16'h0000);
    chk({14'h0, edge_count}, 16'h0001);
    $display("test reset values done");
    @(posedge core_clk);
    rstn <= 1'b1;
    run(40);
    @(negedge core_clk);
    chk({14'h0, duty_mode}, {14'h0, PAT_DUTY_RESTORE});
    chk({14'h0, edge_count}, 16'h0001);
    chk({2'b00, data_oe}, 16'h3fff);
    $display("test binary stream done");
    @(posedge core_clk);
    output_format_select <= 1'b0;
    duty_restore_pin <= 1'b0;
    fmt_cyc = cyc;
    drive(14'h0000, 1'b1);
    drive(14'h3fff, 1'b1);
    drive(14'h2000, 1'b0);
    drive(14'h1fff, 1'b0);
    drive(14'h0001, 1'b0);
    run(30);
    @(negedge core_clk);
    chk({14'h0, duty_mode}, {14'h0, PAT_DUTY_BOTH_EDGES});
    chk({14'h0, edge_count}, 16'h0002);
    $display("test two's complement stream done");
    @(posedge core_clk);
    output_enable_n <= 1'b1;
    run(5);
    @(negedge core_clk);
    chk({2'b00, data_oe}, 16'h0000);
    chk({15'h0, oor_oe}, 16'h0000);
    @(posedge core_clk);
    output_enable_n <= 1'b0;
    run(15);
    @(negedge core_clk);
    chk({2'b00, data_oe}, 16'h3fff);
    $display("test output enable done");
    give_verdict();
  end
endmodule
`default_nettype wire
